// ### include/irf_regs.vh
// status flag positions, reset values and the repeat mode encoding for the ready-flag block
`ifndef IRF_REGS_VH
`define IRF_REGS_VH

// status bit positions
`define IRF_BIT_ACCESS_RDY 2
`define IRF_BIT_RX_RDY 3
`define IRF_BIT_TX_RDY 4
`define IRF_STATUS_WIDTH 5

// reset values of the flags while the controller is held in reset
`define IRF_RST_TX_RDY 1'b1
`define IRF_RST_RX_RDY 1'b0
`define IRF_RST_ACCESS_RDY 1'b0

// repeat_select encoding
`define IRF_MODE_NONREPEAT 1'b0
`define IRF_MODE_REPEAT 1'b1

`endif

// ### logic/irf_ready_flags.v
// ready-flag status logic for a two-wire serial bus controller
// Summary of operation
// - shift copy from holding sets transmit ready
// - holding register write clears transmit ready
// - writing one clears transmit ready
// - transmit ready forced high during reset
// - receive copy into holding sets receive ready
// - reading receive holding clears receive ready
// - writing one clears receive ready
// - any controller reset clears receive ready
// - access ready set only in master operation
// - settings consumed clears access ready
// - starting on settings clears access ready
// - writing one clears access ready
// - three interrupt requests follow their flags
// - count zero sets access in non-repeat mode unless stop requested
// - repeat mode sets access per word
`timescale 1ns/1ps
`default_nettype none
`include "irf_regs.vh"

module irf_ready_flags (
  // clock and processor reset
  input wire clk,
  input wire reset_n,
  // mode control
  input wire moduleRunBit,
  input wire masterMode,
  input wire repeatSelect,
  input wire stopRequest,
  // controller events, one-cycle pulses
  input wire txCopyToShift,
  input wire rxCopyToHolding,
  input wire txWordSent,
  input wire countReachedZero,
  input wire settingsTaken,
  // software accesses
  input wire txHoldingWrite,
  input wire rxHoldingRead,
  input wire statusWrite,
  input wire [`IRF_STATUS_WIDTH-1:0] statusWriteData,
  // status and interrupt requests
  output wire [`IRF_STATUS_WIDTH-1:0] statusFlags,
  output wire txReadyIrq,
  output wire rxReadyIrq,
  output wire accessReadyIrq,
  output reg stopGenerate
);

  reg txReadyFlag_q;
  reg txReadyFlag_d;
  reg rxReadyFlag_q;
  reg rxReadyFlag_d;
  reg accessReadyFlag_q;
  reg accessReadyFlag_d;

  wire ctrlInReset;
  wire w1cTx;
  wire w1cRx;
  wire w1cAccess;
  wire accessSet;
  wire countSet;
  wire repeatSet;

  // processor reset and run bit low both count as controller reset
  assign ctrlInReset = ~reset_n | ~moduleRunBit;

  assign w1cTx = statusWrite & statusWriteData[`IRF_BIT_TX_RDY];
  assign w1cRx = statusWrite & statusWriteData[`IRF_BIT_RX_RDY];
  assign w1cAccess = statusWrite & statusWriteData[`IRF_BIT_ACCESS_RDY];

  assign countSet = (repeatSelect == `IRF_MODE_NONREPEAT) & countReachedZero & ~stopRequest;
  assign repeatSet = (repeatSelect == `IRF_MODE_REPEAT) & txWordSent;
  assign accessSet = masterMode & (countSet | repeatSet);

  always @*
  begin
    txReadyFlag_d = txReadyFlag_q;
    if (txHoldingWrite)
    begin
      txReadyFlag_d = 1'b0;
    end
    if (w1cTx)
    begin
      txReadyFlag_d = 1'b0;
    end
    if (txCopyToShift)
    begin
      txReadyFlag_d = 1'b1;
    end
    if (ctrlInReset)
    begin
      txReadyFlag_d = `IRF_RST_TX_RDY;
    end
  end

  always @*
  begin
    rxReadyFlag_d = rxReadyFlag_q;
    if (rxHoldingRead)
    begin
      rxReadyFlag_d = 1'b0;
    end
    if (w1cRx)
    begin
      rxReadyFlag_d = 1'b0;
    end
    if (rxCopyToHolding)
    begin
      rxReadyFlag_d = 1'b1;
    end
    if (ctrlInReset)
    begin
      rxReadyFlag_d = `IRF_RST_RX_RDY;
    end
  end

  always @*
  begin
    accessReadyFlag_d = accessReadyFlag_q;
    if (settingsTaken)
    begin
      accessReadyFlag_d = 1'b0;
    end
    if (w1cAccess)
    begin
      accessReadyFlag_d = 1'b0;
    end
    if (accessSet)
    begin
      accessReadyFlag_d = 1'b1;
    end
    if (ctrlInReset)
    begin
      accessReadyFlag_d = `IRF_RST_ACCESS_RDY;
    end
  end

  always @(posedge clk)
  begin
    txReadyFlag_q <= txReadyFlag_d;
    rxReadyFlag_q <= rxReadyFlag_d;
    accessReadyFlag_q <= accessReadyFlag_d;
    if (ctrlInReset)
    begin
      stopGenerate <= 1'b0;
    end
    else
    begin
      stopGenerate <= masterMode & (repeatSelect == `IRF_MODE_NONREPEAT)
        & countReachedZero & stopRequest;
    end
  end

  assign statusFlags = {txReadyFlag_q, rxReadyFlag_q, accessReadyFlag_q, 2'h0};

  assign txReadyIrq = txReadyFlag_q;
  assign rxReadyIrq = rxReadyFlag_q;
  assign accessReadyIrq = accessReadyFlag_q;

endmodule
`default_nettype wire

// ### bench/irf_ready_flags_props.sv
// ready-flag port checks
`timescale 1ns/1ps
`default_nettype none
module irf_ready_flags_props (
  input wire logic clk, reset_n, moduleRunBit, masterMode, stopRequest, countReachedZero,
  input wire logic txCopyToShift, rxCopyToHolding, txHoldingWrite, rxHoldingRead, settingsTaken,
  input wire logic stopGenerate,
  input wire logic [4:0] statusFlags
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  wire r = moduleRunBit;
  property p_t1; r && txCopyToShift |=> statusFlags[4]; endproperty
  a_t1: assert property (p_t1) else $error("t1");
  property p_t0; r && !txCopyToShift && txHoldingWrite |=> !statusFlags[4]; endproperty
  a_t0: assert property (p_t0) else $error("t0");
  property p_rs; !r |=> statusFlags == 5'h10; endproperty
  a_rs: assert property (p_rs) else $error("rs");
  property p_r1; r && rxCopyToHolding |=> statusFlags[3]; endproperty
  a_r1: assert property (p_r1) else $error("r1");
  property p_r0; r && !rxCopyToHolding && rxHoldingRead |=> !statusFlags[3]; endproperty
  a_r0: assert property (p_r0) else $error("r0");
  property p_a0; r && !masterMode && settingsTaken |=> !statusFlags[2]; endproperty
  a_a0: assert property (p_a0) else $error("a0");
  property p_nm; !masterMode && !statusFlags[2] |=> !statusFlags[2]; endproperty
  a_nm: assert property (p_nm) else $error("nm");
  property p_sp; stopGenerate |-> $past(countReachedZero && stopRequest); endproperty
  a_sp: assert property (p_sp) else $error("sp");
endmodule
bind irf_ready_flags irf_ready_flags_props u_props (.*);
`default_nettype wire

// ### bench/tb_top.sv
// random bench for ready flags
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0;
  logic reset_n = 0;
  logic [31:0] r = 32'hc4671678;
  logic [3:0] e;
  wire [8:0] y;
  int n_fail, samples_checked;
  irf_ready_flags u_dut (.clk, .reset_n, .moduleRunBit(|r[27:24]), .masterMode(r[15]),
    .repeatSelect(r[14]), .stopRequest(r[13]), .txCopyToShift(r[12]), .rxCopyToHolding(r[11]),
    .txWordSent(r[10]), .countReachedZero(r[9]), .settingsTaken(r[8]), .txHoldingWrite(r[7]),
    .rxHoldingRead(r[6]), .statusWrite(r[5]), .statusWriteData(r[4:0]), .statusFlags(y[8:4]),
    .txReadyIrq(y[3]), .rxReadyIrq(y[2]), .accessReadyIrq(y[1]), .stopGenerate(y[0]));
  function logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], ^(x & 32'h80200003)};
  endfunction
  function logic [3:0] model(input logic [3:0] q, input logic [31:0] x);
    logic [4:0] c;
    c = {5{x[5]}} & x[4:0];
    if (!reset_n || x[27:24] == 4'h0)
      return 4'h8;
    return {x[12] | q[3] & !(x[7] | c[4]), x[11] | q[2] & !(x[6] | c[3]),
      x[15] & (x[14] ? x[10] : x[9] & !x[13]) | q[1] & !(x[8] | c[2]),
      x[15] & !x[14] & x[9] & x[13]};
  endfunction
  always @(posedge clk)
    e <= model(e, r);
  task check(input logic [8:0] g, w);
    samples_checked++;
    if (g !== w)
    begin
      n_fail++;
      $display("mismatch %0t flags got %h want %h", $time, g, w);
    end
  endtask
  task print_verdict;
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
    forever #5 clk = ~clk;
  initial
  begin
    #40000;
    n_fail++;
    print_verdict;
  end
  initial
  begin
    repeat (8) @(negedge clk);
    repeat (3000)
    begin
      check(y, {e[3:1], 2'h0, e});
      repeat (8) r = nx(r);
      // all events at once now and then
      if (r[22:19] == 4'h0)
        r[12:5] = 8'hff;
      reset_n = |r[31:28];
      @(negedge clk);
    end
    print_verdict;
  end
endmodule
`default_nettype wire
